// file: core/ppb_decoder_pkg.sv
// Constants and types for the private peripheral region access decoder
package ppb_decoder_pkg;
    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [31:0] PPB_BASE = 32'hE000_0000;
    localparam logic [31:0] PPB_LIMIT = 32'hE010_0000;
    localparam logic [19:0] SCS_PAGE = 20'hE000E;
    localparam logic [2:0] SYS_REGION = 3'h7;
    // Default map, one bit per 0.5GB region: execute-never and device type
    localparam logic [7:0] DEF_XN_MAP = 8'hE4;
    localparam logic [7:0] DEF_DEV_MAP = 8'hE4;
    // Group bounds inside the 4KB control space (low 12 address bits)
    localparam logic [11:0] ICTR_LO = 12'h000;
    localparam logic [11:0] ICTR_HI = 12'h00F;
    localparam logic [11:0] TICK_LO = 12'h010;
    localparam logic [11:0] TICK_HI = 12'h0FF;
    localparam logic [11:0] IRQ_LO = 12'h100;
    localparam logic [11:0] IRQ_HI = 12'hCFF;
    localparam logic [11:0] CCB_LO = 12'hD00;
    localparam logic [11:0] CCB_HI = 12'hD8F;
    localparam logic [11:0] MPU_LO = 12'hD90;
    localparam logic [11:0] MPU_HI = 12'hDEF;
    localparam logic [11:0] DBG_LO = 12'hDF0;
    localparam logic [11:0] DBG_HI = 12'hEFF;
    localparam logic [11:0] TRIG_LO = 12'hF00;
    localparam logic [11:0] TRIG_HI = 12'hF4F;
    localparam logic [11:0] CACHE_LO = 12'hF50;
    localparam logic [11:0] CACHE_HI = 12'hF8F;
    localparam logic [11:0] IMPL_LO = 12'hF90;
    localparam logic [11:0] IMPL_HI = 12'hFCF;
    localparam logic [11:0] MCU_ID_LO = 12'hFD0;
    localparam logic [11:0] SW_TRIG_OFS = 12'hF00;
    // Byte-field priority and fault status words that allow narrow access
    localparam logic [11:0] BYTEF_LO = 12'hD18;
    localparam logic [11:0] BYTEF_HI = 12'hD2B;
    // Reserved words inside the core control block
    localparam logic [11:0] RSV_A_LO = 12'hD40;
    localparam logic [11:0] RSV_A_HI = 12'hD87;
    localparam logic [11:0] RSV_B_LO = 12'hD8C;
    // ------------------------------------------------------------
    // Bus-side registers
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] FADDR_OFS = 12'h008;
    localparam int PROT_EN_BIT = 0;
    localparam int PRIV_DEF_BIT = 1;
    localparam int UNPRIV_TRIG_BIT = 2;
    localparam int ACC_FAULT_BIT = 0;
    localparam int SIZE_ERR_BIT = 1;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [31:0] FADDR_RESET = 32'h0000_0000;
    // Access sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic [1:0] size;
        logic priv;
        logic [31:0] wdata;
    } core_req_type;
    typedef struct packed {
        logic ictr_aux;
        logic tick;
        logic irq_ctl;
        logic ccb;
        logic memory_protection_unit;
        logic debug;
        logic trigger;
        logic cache_maint;
        logic impl_def;
        logic mcu_id;
        logic ppb_other;
        logic outside;
    } target_sel_type;
    typedef struct packed {
        logic strongly_ordered;
        logic execute_never;
        logic device;
        logic default_map;
        logic map_miss;
    } attr_type;
endpackage

// file: core/ppb_access_decoder.sv
// Access decoder and checker for the private peripheral region
`timescale 1ns/1ns
// Notes on behaviour
// R01: Default map when protection absent or off
// R02: Default map as privileged background only
// R03: System region stays execute-never always
// R04: Private region accesses are strongly ordered
// R05: Register data always little endian; narrow writes from a big-endian core pass unswapped
// R06: Word accesses only unless register allows
// R07: Byte-field registers accept narrow accesses
// R08: Read returning one clears the bit
// R09: Read returning zero keeps coinciding set
// R10: Reserved words read zero, writes ignored
// R11: Unprivileged private region access faults
// R12: Config bit permits unprivileged trigger writes
// R13: Control space is a 4KB word window
// R14: First words and tick timer decoded
// R15: Interrupt controller range routed there
// R16: Protection unit range above control block
// R17: Debug range routed to debug registers
// R18: Trigger range and cache maintenance decoded
// R19: Requester supplies privilege with each access
// R20: Identification ranges decoded separately, no alias
module ppb_access_decoder #(
    parameter int PROT_PRESENT = 1,
    parameter int APB_AW = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ppb_decoder_pkg::core_req_type core_req,
    input wire logic core_big_endian,
    input wire logic prot_hit,
    input wire logic prot_xn,
    input wire logic tgt_rvalid,
    input wire logic [31:0] tgt_rdata,
    output logic rsp_valid,
    output logic rsp_fault,
    output logic rsp_size_err,
    output logic rsp_reserved,
    output ppb_decoder_pkg::target_sel_type rsp_target,
    output ppb_decoder_pkg::attr_type rsp_attr,
    output logic [31:0] rsp_wdata,
    output logic core_rvalid,
    output logic [31:0] core_rdata
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    generate
        if (PROT_PRESENT != 0 && PROT_PRESENT != 1) begin : g_bad_prot
            $error("PROT_PRESENT must be 0 or 1");
        end
        if (APB_AW < 4 || APB_AW > 12) begin : g_bad_aw
            $error("APB_AW must be 4 to 12");
        end
    endgenerate

    logic [2:0] ctrl_ff;
    logic [1:0] stat_ff;
    logic [31:0] faddr_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic rsp_valid_ff;
    logic rsp_fault_ff;
    logic rsp_size_err_ff;
    logic rsp_reserved_ff;
    ppb_decoder_pkg::target_sel_type rsp_target_ff;
    ppb_decoder_pkg::attr_type rsp_attr_ff;
    logic [31:0] rsp_wdata_ff;
    logic core_rvalid_ff;
    logic [31:0] core_rdata_ff;

    // ------------------------------------------------------------
    // Region decode of the core request
    // ------------------------------------------------------------
    // Whole-region and control-space hits
    wire [31:0] a = core_req.addr;
    wire [11:0] ofs = a[11:0];
    wire ppb_hit = (a >= ppb_decoder_pkg::PPB_BASE) && (a < ppb_decoder_pkg::PPB_LIMIT);
    wire scs_hit = (a[31:12] == ppb_decoder_pkg::SCS_PAGE); // R13
    wire [2:0] region = a[31:29];

    // Group selects inside the control space, disjoint by construction
    wire sel_ictr = scs_hit && ofs <= ppb_decoder_pkg::ICTR_HI; // R14
    wire sel_tick = scs_hit && ofs >= ppb_decoder_pkg::TICK_LO
        && ofs <= ppb_decoder_pkg::TICK_HI; // R14
    wire sel_irq = scs_hit && ofs >= ppb_decoder_pkg::IRQ_LO
        && ofs <= ppb_decoder_pkg::IRQ_HI; // R15
    wire sel_ccb = scs_hit && ofs >= ppb_decoder_pkg::CCB_LO
        && ofs <= ppb_decoder_pkg::CCB_HI; // R16
    wire sel_mpu = scs_hit && ofs >= ppb_decoder_pkg::MPU_LO
        && ofs <= ppb_decoder_pkg::MPU_HI; // R16
    wire sel_dbg = scs_hit && ofs >= ppb_decoder_pkg::DBG_LO
        && ofs <= ppb_decoder_pkg::DBG_HI; // R17
    wire sel_trig = scs_hit && ofs >= ppb_decoder_pkg::TRIG_LO
        && ofs <= ppb_decoder_pkg::TRIG_HI; // R18
    wire sel_cache = scs_hit && ofs >= ppb_decoder_pkg::CACHE_LO
        && ofs <= ppb_decoder_pkg::CACHE_HI; // R18
    wire sel_impl = scs_hit && ofs >= ppb_decoder_pkg::IMPL_LO
        && ofs <= ppb_decoder_pkg::IMPL_HI; // R20
    wire sel_mcu = scs_hit && ofs >= ppb_decoder_pkg::MCU_ID_LO; // R20
    wire sel_other = ppb_hit && !scs_hit;
    wire rsv_hit = sel_ccb && ((ofs >= ppb_decoder_pkg::RSV_A_LO
        && ofs <= ppb_decoder_pkg::RSV_A_HI) || ofs >= ppb_decoder_pkg::RSV_B_LO);

    // Size checks: words only, byte-field words may be narrow if aligned
    wire is_word = core_req.size == ppb_decoder_pkg::SIZE_WORD;
    wire is_half = core_req.size == ppb_decoder_pkg::SIZE_HALF;
    wire is_byte = core_req.size == ppb_decoder_pkg::SIZE_BYTE;
    wire bytef_hit = sel_ccb && ofs >= ppb_decoder_pkg::BYTEF_LO
        && ofs <= ppb_decoder_pkg::BYTEF_HI; // R07
    wire aligned = is_word ? (a[1:0] == 2'h0) : is_half ? !a[0] : is_byte;
    wire narrow_ok = bytef_hit && (is_byte || is_half) && aligned; // R07
    wire size_bad = ppb_hit && !(is_word && aligned) && !narrow_ok; // R06

    // Privilege check with the trigger write exemption
    wire trig_exempt = sel_trig && ofs[11:2] == ppb_decoder_pkg::SW_TRIG_OFS[11:2]
        && core_req.write && ctrl_ff[ppb_decoder_pkg::UNPRIV_TRIG_BIT]; // R12
    wire unpriv_bad = ppb_hit && !core_req.priv && !trig_exempt; // R11 R19
    wire fault_now = unpriv_bad || size_bad;

    // Default map selection and attributes
    wire prot_on = (PROT_PRESENT == 1) && ctrl_ff[ppb_decoder_pkg::PROT_EN_BIT];
    wire bg_ok = ctrl_ff[ppb_decoder_pkg::PRIV_DEF_BIT] && core_req.priv; // R02
    wire use_default = !prot_on || (!prot_hit && bg_ok); // R01 R02
    wire miss = prot_on && !prot_hit && !bg_ok;
    wire def_xn = ppb_decoder_pkg::DEF_XN_MAP[region];
    wire xn_now = (region == ppb_decoder_pkg::SYS_REGION)
        || (use_default ? def_xn : (prot_xn || miss)); // R03

    // Target select word
    ppb_decoder_pkg::target_sel_type tsel;
    assign tsel = '{ictr_aux: sel_ictr, tick: sel_tick, irq_ctl: sel_irq,
        ccb: sel_ccb && !rsv_hit, memory_protection_unit: sel_mpu, debug: sel_dbg, trigger: sel_trig,
        cache_maint: sel_cache, impl_def: sel_impl, mcu_id: sel_mcu,
        ppb_other: sel_other, outside: !ppb_hit};

    // Byte swap towards the registers for word accesses of a big-endian core
    function automatic logic [31:0] swap32(input logic [31:0] d);
        swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction
    wire swap_en = core_big_endian && is_word;
    wire [31:0] wdata_le = swap_en ? swap32(core_req.wdata) : core_req.wdata; // R05

    // ------------------------------------------------------------
    // Response stage
    // ------------------------------------------------------------
    // One registered answer per request; faulted or reserved hits select nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_valid_ff <= 1'b0;
            rsp_fault_ff <= 1'b0;
            rsp_size_err_ff <= 1'b0;
            rsp_reserved_ff <= 1'b0;
            rsp_target_ff <= '0;
            rsp_attr_ff <= '0;
            rsp_wdata_ff <= 32'h0000_0000;
        end else begin
            rsp_valid_ff <= core_req.valid;
            if (core_req.valid) begin
                rsp_fault_ff <= fault_now; // R11
                rsp_size_err_ff <= size_bad; // R06
                rsp_reserved_ff <= rsv_hit && !fault_now; // R10
                rsp_target_ff <= fault_now ? '0 : tsel;
                rsp_attr_ff <= '{strongly_ordered: ppb_hit, // R04
                    execute_never: xn_now,
                    device: ppb_decoder_pkg::DEF_DEV_MAP[region],
                    default_map: use_default, map_miss: miss};
                rsp_wdata_ff <= wdata_le;
            end
        end
    end

    // Load data from the targets back to the core, swapped to its order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_rvalid_ff <= 1'b0;
            core_rdata_ff <= 32'h0000_0000;
        end else begin
            core_rvalid_ff <= tgt_rvalid;
            if (tgt_rvalid) begin
                core_rdata_ff <= core_big_endian ? swap32(tgt_rdata) : tgt_rdata; // R05
            end
        end
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    wire [11:0] pofs = 12'(paddr);
    wire access = psel && penable;
    wire taken = access && pready_ff;
    wire hit_ctrl = pofs == ppb_decoder_pkg::CTRL_OFS;
    wire hit_stat = pofs == ppb_decoder_pkg::STAT_OFS;
    wire hit_faddr = pofs == ppb_decoder_pkg::FADDR_OFS;
    wire mapped = hit_ctrl || hit_stat || hit_faddr;
    wire stat_rd = taken && !pwrite && hit_stat && !pslverr_ff;
    wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_ff}
        : hit_stat ? {30'h0, stat_ff} : hit_faddr ? faddr_ff : 32'h0000_0000;

    // One wait state, answer and read data from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= access && !pready_ff;
            pslverr_ff <= access && !pready_ff && !mapped;
            if (access && !pready_ff) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // Control bits, written at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= ppb_decoder_pkg::CTRL_RESET;
        end else if (taken && pwrite && hit_ctrl) begin
            ctrl_ff <= pwdata[2:0];
        end
    end

    // Clear-on-read status: only bits that were returned as one are cleared
    logic [1:0] set_ev;
    logic [1:0] nxt_stat;
    assign set_ev = {core_req.valid && size_bad, core_req.valid && fault_now};
    assign nxt_stat = stat_rd ? ((stat_ff & ~prdata_ff[1:0]) | (set_ev & ~prdata_ff[1:0]))
        : (stat_ff | set_ev); // R08 R09
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff <= ppb_decoder_pkg::STAT_RESET;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // Address of the most recent faulting access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faddr_ff <= ppb_decoder_pkg::FADDR_RESET;
        end else if (core_req.valid && fault_now) begin
            faddr_ff <= a;
        end
    end

    // Outputs
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_fault = rsp_fault_ff;
    assign rsp_size_err = rsp_size_err_ff;
    assign rsp_reserved = rsp_reserved_ff;
    assign rsp_target = rsp_target_ff;
    assign rsp_attr = rsp_attr_ff;
    assign rsp_wdata = rsp_wdata_ff;
    assign core_rvalid = core_rvalid_ff;
    assign core_rdata = core_rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_req_unpriv;
        core_req.valid && ppb_hit && !core_req.priv && !trig_exempt;
    endsequence
    sequence s_trig_ok;
        core_req.valid && trig_exempt && (is_word && aligned);
    endsequence
    sequence s_stat_rd_one;
        stat_rd && prdata_ff[ppb_decoder_pkg::ACC_FAULT_BIT];
    endsequence

    a_unpriv_fault: assert property (s_req_unpriv |=> rsp_valid && rsp_fault) // R11
        else $error("unprivileged access not faulted");
    a_trig_exempt: assert property (s_trig_ok |=> !rsp_fault && rsp_target.trigger) // R12
        else $error("exempt trigger write faulted");
    a_sys_xn: assert property (core_req.valid && region == 3'h7 |=> rsp_attr.execute_never) // R03
        else $error("system region lost execute-never");
    a_ppb_order: assert property (core_req.valid && ppb_hit |=> rsp_attr.strongly_ordered) // R04
        else $error("private region not strongly ordered");
    a_default_off: assert property (core_req.valid && !prot_on |=> rsp_attr.default_map) // R01
        else $error("default map unused with protection off");
    a_bg_unpriv: assert property (core_req.valid && prot_on && !core_req.priv
        |=> !rsp_attr.default_map || $past(!prot_on)) // R02
        else $error("background map given to unprivileged access");
    a_size_check: assert property (core_req.valid && ppb_hit && is_half && !bytef_hit
        |=> rsp_size_err && rsp_target == '0) // R06
        else $error("narrow access outside byte-field words accepted");
    a_narrow_ok: assert property (core_req.valid && core_req.priv && narrow_ok
        |=> !rsp_fault && rsp_target.ccb) // R07
        else $error("narrow byte-field access refused");
    a_cor_clear: assert property (s_stat_rd_one |=> !stat_ff[0]) // R08
        else $error("read of one did not clear");
    a_cor_keep: assert property (stat_rd && !prdata_ff[0] && set_ev[0] |=> stat_ff[0] ##1
        (stat_ff[0] || $past(stat_rd))) // R09
        else $error("coinciding set lost on read of zero");
    a_le_swap: assert property (core_req.valid && swap_en
        |=> rsp_wdata == swap32($past(core_req.wdata))) // R05
        else $error("write data not little endian");
    a_tick_route: assert property (core_req.valid && core_req.priv && is_word && aligned
        && scs_hit && ofs == 12'h010 |=> rsp_target.tick && !rsp_target.ictr_aux) // R14
        else $error("tick timer misrouted");
    a_mpu_route: assert property (core_req.valid && core_req.priv && is_word && aligned
        && scs_hit && ofs == 12'hD90 |=> rsp_target.memory_protection_unit && !rsp_target.ccb) // R16
        else $error("protection unit misrouted");
    a_apb_wait: assert property (psel && penable && !pready |=> pready) // R13
        else $error("bus answer late");
endmodule

// file: tb/core_lsu_model.sv
// Behavioural load/store unit and target read responder around the decoder
`timescale 1ns/1ns
module core_lsu_model #(
    parameter logic [31:0] TGT_DATA = 32'h1122_3344
) (
    input wire logic pclk,
    input wire logic rsp_valid,
    input wire ppb_decoder_pkg::target_sel_type rsp_target,
    output ppb_decoder_pkg::core_req_type core_req,
    output logic tgt_rvalid,
    output logic [31:0] tgt_rdata
);
    logic last_wr;
    initial begin
        core_req = '0;
        tgt_rvalid = 1'b0;
        tgt_rdata = 32'h0000_0000;
        last_wr = 1'b0;
    end
    // One request per call, each carrying its privilege level; fields other than size scrambled when idle
    task automatic issue(input logic [31:0] a, input logic [1:0] sz, input logic pv,
                         input logic wr, input logic [31:0] wd);
        begin
            @(posedge pclk);
            core_req <= '{valid: 1'b1, addr: a, write: wr, size: sz, priv: pv, wdata: wd};
            last_wr = wr;
            @(posedge pclk);
            core_req <= '{valid: 1'b0, addr: ~a, write: ~wr, size: sz, priv: ~pv, wdata: ~wd};
            #1;
        end
    endtask
    // Selected target returns read data one cycle after the response, toggling otherwise
    always @(posedge pclk) begin
        tgt_rvalid <= rsp_valid && !last_wr && (rsp_target != '0);
        tgt_rdata <= (rsp_valid && !last_wr) ? TGT_DATA : ~tgt_rdata;
    end
endmodule

// file: tb/ppb_access_decoder_tb_top.sv
// Self-checking testbench for the private region access decoder
`timescale 1ns/1ns
module ppb_access_decoder_tb_top;
    typedef struct {logic [31:0] a; logic [1:0] sz; logic pv; logic [11:0] tg; logic f;} row_type;
    typedef struct {logic [2:0] c; logic h; logic x; logic [31:0] a; logic pv; logic [2:0] e;}
        mrow_type;
    localparam logic [1:0] W = ppb_decoder_pkg::SIZE_WORD;
    localparam logic [1:0] H = ppb_decoder_pkg::SIZE_HALF;
    localparam logic [1:0] B = ppb_decoder_pkg::SIZE_BYTE;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, core_big_endian, prot_hit, prot_xn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, tgt_rdata, rsp_wdata, core_rdata, rd, rd2;
    logic tgt_rvalid, rsp_valid, rsp_fault, rsp_size_err, rsp_reserved, core_rvalid, er;
    ppb_decoder_pkg::core_req_type core_req;
    ppb_decoder_pkg::target_sel_type rsp_target;
    ppb_decoder_pkg::attr_type rsp_attr;
    int num_errors = 0;
    int num_checks = 0;
    int n;
    // Decode table: address, size, privilege, one-hot target, fault
    row_type rows [17] = '{
        '{32'hE000_E000, W, 1'b1, 12'h800, 1'b0}, '{32'hE000_E010, W, 1'b1, 12'h400, 1'b0},
        '{32'hE000_E100, W, 1'b1, 12'h200, 1'b0}, '{32'hE000_ECFC, W, 1'b1, 12'h200, 1'b0},
        '{32'hE000_ED00, W, 1'b1, 12'h100, 1'b0}, '{32'hE000_ED90, W, 1'b1, 12'h080, 1'b0},
        '{32'hE000_EDF0, W, 1'b1, 12'h040, 1'b0}, '{32'hE000_EF00, W, 1'b1, 12'h020, 1'b0},
        '{32'hE000_EF50, W, 1'b1, 12'h010, 1'b0}, '{32'hE000_EF90, W, 1'b1, 12'h008, 1'b0},
        '{32'hE000_EFD0, W, 1'b1, 12'h004, 1'b0}, '{32'hE000_0000, W, 1'b1, 12'h002, 1'b0},
        '{32'hE010_0000, W, 1'b1, 12'h001, 1'b0}, '{32'hE000_E010, W, 1'b0, 12'h000, 1'b1},
        '{32'hE000_ED18, B, 1'b1, 12'h100, 1'b0}, '{32'hE000_ED1A, H, 1'b1, 12'h100, 1'b0},
        '{32'hE000_ED00, H, 1'b1, 12'h000, 1'b1}};
    // Map table: ctrl, hit, prot xn, address, privilege, expected {xn, default map, miss}
    mrow_type mrows [8] = '{
        '{3'h0, 1'b0, 1'b0, 32'h2000_0000, 1'b1, 3'h2}, '{3'h0, 1'b0, 1'b0, 32'h4000_0000, 1'b1, 3'h6},
        '{3'h3, 1'b0, 1'b0, 32'h2000_0000, 1'b1, 3'h2}, '{3'h3, 1'b0, 1'b0, 32'h2000_0000, 1'b0, 3'h5},
        '{3'h1, 1'b0, 1'b0, 32'h2000_0000, 1'b1, 3'h5}, '{3'h1, 1'b1, 1'b0, 32'hE010_0000, 1'b1, 3'h4},
        '{3'h1, 1'b1, 1'b1, 32'h2000_0000, 1'b1, 3'h4}, '{3'h1, 1'b1, 1'b0, 32'h2000_0000, 1'b1, 3'h0}};

    ppb_access_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core_req(core_req), .core_big_endian(core_big_endian),
        .prot_hit(prot_hit), .prot_xn(prot_xn), .tgt_rvalid(tgt_rvalid), .tgt_rdata(tgt_rdata),
        .rsp_valid(rsp_valid), .rsp_fault(rsp_fault), .rsp_size_err(rsp_size_err),
        .rsp_reserved(rsp_reserved), .rsp_target(rsp_target), .rsp_attr(rsp_attr),
        .rsp_wdata(rsp_wdata), .core_rvalid(core_rvalid), .core_rdata(core_rdata));
    core_lsu_model u_core (.pclk(pclk), .rsp_valid(rsp_valid), .rsp_target(rsp_target),
        .core_req(core_req), .tgt_rvalid(tgt_rvalid), .tgt_rdata(tgt_rdata));

    always #20 pclk = ~pclk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // APB transfer held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic test_done();
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, core_big_endian, prot_hit, prot_xn} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ppb_decoder_pkg::STAT_OFS, 32'h0, rd, er);
        chk("status_reset", rd, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0, rd, er);
        chk("unmapped_err", {er, rd[30:0]}, 32'h8000_0000);
        foreach (rows[i]) begin
            u_core.issue(rows[i].a, rows[i].sz, rows[i].pv, 1'b0, 32'h0);
            chk("rsp_valid", {31'h0, rsp_valid}, 32'h1);
            chk("target", {20'h0, rsp_target}, {20'h0, rows[i].tg});
            chk("fault", {31'h0, rsp_fault}, {31'h0, rows[i].f});
            chk("ordered", {31'h0, rsp_attr.strongly_ordered},
                {31'h0, rows[i].a[31:20] == 12'hE00});
            chk("xn_sys", {31'h0, rsp_attr.execute_never}, 32'h1);
        end
        apb(1'b0, ppb_decoder_pkg::STAT_OFS, 32'h0, rd, er);
        chk("status_set", {31'h0, rd[0]}, 32'h1);
        apb(1'b0, ppb_decoder_pkg::FADDR_OFS, 32'h0, rd, er);
        chk("fault_addr", rd, 32'hE000_ED00);
        apb(1'b0, ppb_decoder_pkg::STAT_OFS, 32'h0, rd, er);
        chk("status_clear", {31'h0, rd[0]}, 32'h0);
        // Fault raised while a status read is in flight: exactly one read sees it
        fork
            apb(1'b0, ppb_decoder_pkg::STAT_OFS, 32'h0, rd, er);
            begin
                @(posedge pclk);
                u_core.issue(32'hE000_E010, W, 1'b0, 1'b0, 32'h0);
            end
        join
        apb(1'b0, ppb_decoder_pkg::STAT_OFS, 32'h0, rd2, er);
        chk("set_seen_once", {31'h0, rd[0] ^ rd2[0]}, 32'h1);
        // Unprivileged trigger write: faults until enabled, reads always fault
        u_core.issue(32'hE000_EF00, W, 1'b0, 1'b1, 32'h5);
        chk("trig_locked", {31'h0, rsp_fault}, 32'h1);
        apb(1'b1, ppb_decoder_pkg::CTRL_OFS, 32'h4, rd, er);
        u_core.issue(32'hE000_EF00, W, 1'b0, 1'b1, 32'h5);
        chk("trig_open", {19'h0, rsp_fault, rsp_target}, 32'h020);
        u_core.issue(32'hE000_EF00, W, 1'b0, 1'b0, 32'h0);
        chk("trig_read", {31'h0, rsp_fault}, 32'h1);
        foreach (mrows[i]) begin
            apb(1'b1, ppb_decoder_pkg::CTRL_OFS, {29'h0, mrows[i].c}, rd, er);
            prot_hit <= mrows[i].h;
            prot_xn <= mrows[i].x;
            u_core.issue(mrows[i].a, W, mrows[i].pv, 1'b0, 32'h0);
            chk("map_attr", {29'h0, rsp_attr.execute_never, rsp_attr.default_map,
                rsp_attr.map_miss}, {29'h0, mrows[i].e});
        end
        u_core.issue(32'hE000_ED40, W, 1'b1, 1'b0, 32'h0);
        chk("reserved", {19'h0, rsp_reserved, rsp_target}, 32'h1000);
        @(posedge pclk);
        core_big_endian <= 1'b1;
        u_core.issue(32'hE000_ED00, W, 1'b1, 1'b1, 32'h1122_3344);
        chk("wdata_swap", rsp_wdata, 32'h4433_2211);
        u_core.issue(32'hE000_ED00, W, 1'b1, 1'b0, 32'h0);
        n = 0;
        while (core_rvalid !== 1'b1 && n < 10) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("rdata_swap", core_rdata, 32'h4433_2211);
        @(posedge pclk);
        core_big_endian <= 1'b0;
        u_core.issue(32'hE000_ED00, W, 1'b1, 1'b1, 32'h1122_3344);
        chk("wdata_plain", rsp_wdata, 32'h1122_3344);
        // Mid-run reset clears the response and the control bits
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset_rsp", {30'h0, rsp_valid, rsp_fault}, 32'h0);
        presetn <= 1'b1;
        apb(1'b0, ppb_decoder_pkg::CTRL_OFS, 32'h0, rd, er);
        chk("ctrl_reset", rd, 32'h0);
        test_done();
    end

    // Watchdog well beyond the roughly 150 cycles the sequence needs
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        test_done();
    end
endmodule
